//--- common/ltm_pkg.sv
// package: mode, pin bundle and timing constants of the link mode controller
package ltm_pkg;

  // operating modes of the transceiver logic
  typedef enum logic [1:0] {
    LTM_SLEEP,
    LTM_FAILSAFE,
    LTM_NORMAL
  } ltm_mode_type;

  // pin levels sampled from outside, carried together through the synchroniser
  typedef struct packed {
    logic bus;   // bus level, 1 = recessive
    logic txd;   // transmit input level
    logic en;    // mode-select level
    logic wake;  // local wake input level, 0 = request
    logic uv;    // supply undervoltage indication, 1 = low supply
  } ltm_pins_type;

  // clock and time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 6;

  // filter and time-out durations, in microseconds; the time-out is first given in milliseconds
  localparam int BUS_WAKE_US = 90;
  localparam int LOCAL_WAKE_US = 35;
  localparam int TXD_HIGH_US = 10;
  localparam int WAKE_REARM_US = 6;
  localparam int DOM_TIMEOUT_MS = 40;
  localparam int DOM_TIMEOUT_US = DOM_TIMEOUT_MS * 1000;

  // microsecond counts; the first tick lands anywhere in the first
  // microsecond, so every filter counts one tick past its time
  localparam int BUS_WAKE_TICKS = (BUS_WAKE_US * 1000) / TICK_NS + 1;
  localparam int LOCAL_WAKE_TICKS = (LOCAL_WAKE_US * 1000) / TICK_NS + 1;
  localparam int TXD_HIGH_TICKS = (TXD_HIGH_US * 1000) / TICK_NS + 1;
  localparam int WAKE_REARM_TICKS = (WAKE_REARM_US * 1000) / TICK_NS + 1;
  localparam int CNT_W = 16;

  // reset values
  localparam logic RXD_RST = 1'b1;
  // synchroniser contents at reset: pins at their idle levels, so no false
  // bus change or wake edge follows reset
  localparam ltm_pins_type PINS_RST =
    '{bus: 1'b1, txd: 1'b0, en: 1'b0, wake: 1'b1, uv: 1'b0};
  localparam logic BUF_DEPTH_BITS = 1'b1;

endpackage

//--- rtl/ltm_mode_ctrl.sv
// mode control and data path of a single-wire vehicle bus transceiver
//
// Functional notes
// - normal mode: transmit low pulls bus dominant, high releases it
// - with time-out built in, transmit low past 40 ms forces recessive
// - after time-out, driver stays off until transmit high over 10 us
// - in normal mode, receive output is high for recessive bus, low for dominant
// - mode-select high means normal mode with both paths enabled
// - mode-select falling while transmit high enters sleep, no transmit
// - mode-select low or open reads low and keeps sleep
// - regulator switch on in normal and fail-safe modes
// - regulator switch off in sleep mode
// - a qualified local or remote wake-up turns regulator switch on
// - at power-up enter fail-safe with regulator switch on
// - supply undervoltage blocks every transmission onto the bus
// - fail-safe mode after a wake-up turns transmit pin into wake-source output
// - after local wake-up the transmit pin is pulled low strongly
// - bus termination only in normal and fail-safe modes
// - in sleep nothing is transmitted until mode-select goes high
// - remote wake-up needs bus dominant for 90 us filter time
// - local wake-up needs wake input low for 35 us filter time
// - fail-safe enters normal when mode-select goes high
// - wake request and wake source flags clear when mode-select rises
// - wake source: weak pull-down for remote, strong for local
// - after entering normal, driver waits for transmit high over 10 us
`timescale 1ns/100ps
`default_nettype none

module ltm_mode_ctrl
  import ltm_pkg::*;
#(
  parameter bit DOM_TIMEOUT_EN = 1'b1,
  parameter int DOM_TIMEOUT_TICKS = DOM_TIMEOUT_US
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic txd_in,
  input wire logic mode_select,
  input wire logic wake_in,
  input wire logic bus_in,
  input wire logic supply_low,
  input wire logic rx_stall,
  output logic bus_drive,
  output logic rxd_out,
  output logic txd_out,
  output logic txd_oe,
  output logic txd_strong,
  output logic regulator_switch_out,
  output logic termination_en,
  output logic rx_buf_ready,
  output logic [1:0] mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser and microsecond tick

  ltm_pins_type pins_raw;
  ltm_pins_type pins_meta_q;
  ltm_pins_type pins_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;

  assign pins_raw = '{bus: bus_in, txd: txd_in, en: mode_select,
                      wake: wake_in, uv: supply_low};

  // two stages; only pins_q is read by any logic
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_meta_q <= PINS_RST;
      pins_q <= PINS_RST;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
    end
  end

  // one-cycle enable every microsecond, base of all filters
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // saturating counter step used by every filter
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c,
                                                input logic run,
                                                input logic tick);
    if (!run) begin
      cnt_step = '0;
    end else if (tick && c != '1) begin
      cnt_step = c + 1'b1;
    end else begin
      cnt_step = c;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wake-up filters

  logic [CNT_W-1:0] bus_dom_cnt_q;
  logic [CNT_W-1:0] wake_low_cnt_q;
  logic [CNT_W-1:0] wake_high_cnt_q;
  logic bus_dom_long_q;
  logic wake_armed_q;
  logic remote_wake;
  logic local_wake;

  // filter counters run only while their level holds
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_dom_cnt_q <= '0;
      wake_low_cnt_q <= '0;
      wake_high_cnt_q <= '0;
    end else begin
      bus_dom_cnt_q <= cnt_step(bus_dom_cnt_q, !pins_q.bus, tick_q);
      wake_low_cnt_q <= cnt_step(wake_low_cnt_q, !pins_q.wake, tick_q);
      wake_high_cnt_q <= cnt_step(wake_high_cnt_q, pins_q.wake, tick_q);
    end
  end

  // remote: dominant long enough, then the rising edge ends the request;
  // a stuck-low wake input is re-armed only after a real high phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_dom_long_q <= 1'b0;
      wake_armed_q <= 1'b0;
    end else begin
      if (pins_q.bus) begin
        bus_dom_long_q <= 1'b0;
      end else if (bus_dom_cnt_q >= CNT_W'(BUS_WAKE_TICKS)) begin
        bus_dom_long_q <= 1'b1;
      end
      if (local_wake) begin
        wake_armed_q <= 1'b0;
      end else if (wake_high_cnt_q >= CNT_W'(WAKE_REARM_TICKS)) begin
        wake_armed_q <= 1'b1;
      end
    end
  end

  assign remote_wake = bus_dom_long_q && pins_q.bus;
  assign local_wake = wake_armed_q &&
                      wake_low_cnt_q >= CNT_W'(LOCAL_WAKE_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing

  ltm_mode_type mode_q;
  logic en_prev_q;
  logic wake_req_q;
  logic wake_local_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= pins_q.en;
    end
  end

  // power-up lands in fail-safe; open mode-select reads low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= LTM_FAILSAFE;
    end else begin
      unique case (mode_q)
        LTM_SLEEP: begin
          if (pins_q.en) begin
            mode_q <= LTM_NORMAL;
          end else if (remote_wake || local_wake) begin
            mode_q <= LTM_FAILSAFE;
          end
        end
        LTM_FAILSAFE: begin
          if (pins_q.en) begin
            mode_q <= LTM_NORMAL;
          end
        end
        LTM_NORMAL: begin
          // low mode-select with transmit high is the sleep command
          if (!pins_q.en && pins_q.txd) begin
            mode_q <= LTM_SLEEP;
          end
        end
      endcase
    end
  end

  // wake flags: set only in sleep, cleared as soon as mode-select rises;
  // a wake and a rise cannot meet since setting needs mode-select low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_req_q <= 1'b0;
      wake_local_q <= 1'b0;
    end else if (mode_q == LTM_SLEEP && !pins_q.en &&
                 (remote_wake || local_wake)) begin
      wake_req_q <= 1'b1;
      wake_local_q <= local_wake;
    end else if (pins_q.en && !en_prev_q) begin
      wake_req_q <= 1'b0;
      wake_local_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: arming and dominant time-out

  logic [CNT_W-1:0] txd_high_cnt_q;
  logic [CNT_W-1:0] txd_low_cnt_q;
  logic drv_armed_q;
  logic dom_to_q;
  logic in_normal;

  assign in_normal = (mode_q == LTM_NORMAL);

  // the time-out can exceed the counter width, so both sides are widened to 32 bits on compare
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_high_cnt_q <= '0;
      txd_low_cnt_q <= '0;
    end else begin
      txd_high_cnt_q <= cnt_step(txd_high_cnt_q, in_normal && pins_q.txd,
                                 tick_q);
      txd_low_cnt_q <= cnt_step(txd_low_cnt_q, in_normal && !pins_q.txd,
                                tick_q);
    end
  end

  // driver idle on entry to normal and after a time-out until a long high
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drv_armed_q <= 1'b0;
      dom_to_q <= 1'b0;
    end else if (!in_normal) begin
      drv_armed_q <= 1'b0;
      dom_to_q <= 1'b0;
    end else if (DOM_TIMEOUT_EN && !pins_q.txd &&
                 32'(txd_low_cnt_q) > 32'(DOM_TIMEOUT_TICKS)) begin
      drv_armed_q <= 1'b0;
      dom_to_q <= 1'b1;
    end else if (txd_high_cnt_q >= CNT_W'(TXD_HIGH_TICKS)) begin
      drv_armed_q <= 1'b1;
      dom_to_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path: two-entry buffer of bus level changes

  logic buf_mem_q [2];
  logic buf_wr_q;
  logic buf_rd_q;
  logic [1:0] buf_cnt_q;
  logic last_push_q;
  logic push;
  logic pop;

  // a pending change waits in pins_q while full, so the final level survives
  assign push = (pins_q.bus != last_push_q) && buf_cnt_q != 2'd2;
  assign pop = buf_cnt_q != 2'd0 && !rx_stall;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_mem_q[0] <= RXD_RST;
      buf_mem_q[1] <= RXD_RST;
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
      buf_cnt_q <= 2'd0;
      last_push_q <= RXD_RST;
    end else begin
      if (push) begin
        buf_mem_q[buf_wr_q] <= pins_q.bus;
        buf_wr_q <= buf_wr_q ^ BUF_DEPTH_BITS;
        last_push_q <= pins_q.bus;
      end
      if (pop) begin
        buf_rd_q <= buf_rd_q ^ BUF_DEPTH_BITS;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic rx_level_q;

  // receive level taken from the buffer head when the reader accepts it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_level_q <= RXD_RST;
    end else if (pop) begin
      rx_level_q <= buf_mem_q[buf_rd_q];
    end
  end

  // every pin output comes from a flop; one cycle after the mode register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_drive <= 1'b0;
      rxd_out <= RXD_RST;
      txd_out <= 1'b0;
      txd_oe <= 1'b0;
      txd_strong <= 1'b0;
      regulator_switch_out <= 1'b1;
      termination_en <= 1'b1;
      rx_buf_ready <= 1'b1;
      mode_out <= 2'(LTM_FAILSAFE);
    end else begin
      // undervoltage and non-normal modes never drive the bus
      bus_drive <= in_normal && drv_armed_q && !dom_to_q &&
                   !pins_q.txd && !pins_q.uv;
      unique case (mode_q)
        LTM_NORMAL: rxd_out <= rx_level_q;
        LTM_FAILSAFE: rxd_out <= !wake_req_q;
        LTM_SLEEP: rxd_out <= 1'b1;
      endcase
      // fail-safe: transmit pin reports the wake source
      txd_out <= 1'b0;
      txd_oe <= (mode_q == LTM_FAILSAFE) && wake_req_q;
      txd_strong <= wake_local_q;
      regulator_switch_out <= mode_q != LTM_SLEEP;
      termination_en <= mode_q != LTM_SLEEP;
      rx_buf_ready <= buf_cnt_q != 2'd2 || pop;
      mode_out <= 2'(mode_q);
    end
  end

endmodule

`default_nettype wire

//--- testbench/ltm_bus_model.sv
// partner: the shared bus wire with a remote node on it
`timescale 1ns/100ps
`default_nettype none
module ltm_bus_model (
  input wire logic bus_drive,
  input wire logic remote_dom,
  output logic bus_level
);
  // wired-and bus, the pull-up makes it recessive when nobody pulls
  assign bus_level = !(bus_drive || remote_dom);
endmodule
`default_nettype wire

//--- testbench/ltm_mode_ctrl_sva.sv
// checker: port relations of the link mode controller
`timescale 1ns/100ps
`default_nettype none
module ltm_mode_ctrl_sva
  import ltm_pkg::*;
#(
  parameter bit DOM_TIMEOUT_EN = 1'b1,
  parameter int DOM_TIMEOUT_TICKS = DOM_TIMEOUT_US
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic txd_in,
  input wire logic mode_select,
  input wire logic wake_in,
  input wire logic supply_low,
  input wire logic bus_drive,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic txd_strong,
  input wire logic regulator_switch_out,
  input wire logic termination_en,
  input wire logic [1:0] mode_out
);
  // one tick of filter jitter plus sync stages allowed on the time-out
  localparam int DOM_MAX = (DOM_TIMEOUT_TICKS + 2) * TICK_CYCLES;
  // the filter time itself in clock cycles, not the design's tick count
  localparam int WAKE_MIN = LOCAL_WAKE_US * 1000 / CLK_PERIOD_NS;
  int dom_cnt;
  int wlow_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // run lengths of a dominant drive and of a low wake input
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dom_cnt <= 0;
      wlow_cnt <= 0;
    end else begin
      dom_cnt <= bus_drive ? dom_cnt + 1 : 0;
      wlow_cnt <= wake_in ? 0 : wlow_cnt + 1;
    end
  end
  ////////////////////////////////////////
  reg_follow_a: assert property (
    regulator_switch_out == (mode_out != LTM_SLEEP))
    else $error("regulator switch disagrees with mode");
  term_follow_a: assert property (
    termination_en == (mode_out != LTM_SLEEP))
    else $error("termination disagrees with mode");
  drive_normal_a: assert property (
    bus_drive |-> mode_out == LTM_NORMAL || $past(mode_out) == LTM_NORMAL)
    else $error("bus driven outside normal mode");
  uv_block_a: assert property (supply_low [*4] |=> !bus_drive)
    else $error("bus driven under low supply");
  txd_release_a: assert property (txd_in [*4] |=> !bus_drive)
    else $error("bus driven while transmit high");
  dom_limit_a: assert property (
    !DOM_TIMEOUT_EN || dom_cnt <= DOM_MAX)
    else $error("dominant drive outlasts time-out");
  enter_normal_a: assert property (
    mode_select [*6] |=> mode_out == LTM_NORMAL && !txd_oe)
    else $error("mode-select high without normal mode");
  local_filter_a: assert property (
    $rose(txd_strong) |-> wlow_cnt >= WAKE_MIN)
    else $error("local wake taken before filter time");
  power_up_a: assert property (
    $fell(sys_rst) |-> mode_out == LTM_FAILSAFE && regulator_switch_out)
    else $error("power-up not in fail-safe");
  pull_down_a: assert property (
    txd_oe |-> !txd_out && mode_out == LTM_FAILSAFE)
    else $error("transmit pin driven high");
  cover property ($rose(bus_drive));
  cover property ($rose(txd_strong));
  cover property (mode_out == LTM_SLEEP);
endmodule
bind ltm_mode_ctrl ltm_mode_ctrl_sva #(
  .DOM_TIMEOUT_EN(DOM_TIMEOUT_EN), .DOM_TIMEOUT_TICKS(DOM_TIMEOUT_TICKS)
) u_ltm_mode_ctrl_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .txd_in(txd_in),
  .mode_select(mode_select), .wake_in(wake_in), .supply_low(supply_low),
  .bus_drive(bus_drive), .txd_out(txd_out), .txd_oe(txd_oe),
  .txd_strong(txd_strong), .regulator_switch_out(regulator_switch_out),
  .termination_en(termination_en), .mode_out(mode_out));
`default_nettype wire

//--- testbench/test_ltm_mode_ctrl.sv
// testbench: random and corner traffic through the link mode controller
`timescale 1ns/100ps
`default_nettype none
module test_ltm_mode_ctrl
  import ltm_pkg::*;
;
  // short time-out keeps the run brief
  localparam int TO = 50;
  logic ref_clk = 1'b0, sys_rst = 1'b1, txd_q = 1'b0, ms = 1'b0;
  logic wk = 1'b1, rem = 1'b0, uv = 1'b0, stall = 1'b0, b = 1'b0;
  logic bus_in, txd_pin, bus_drive, rxd_out, txd_out, txd_oe, txd_strong;
  logic reg_sw, term_en, rdy;
  logic [1:0] mode;
  logic [31:0] seed = 32'h62fd45dc;
  int bad_count = 0, comparisons = 0, ticks = 0;
  ////////////////////////////////////////
  // while the device reports a wake source it owns the pin: the strong pull-down reads low, the weak one reads high
  assign txd_pin = txd_oe ? !txd_strong : txd_q;
  ltm_bus_model u_ltm_bus_model (.bus_drive(bus_drive),
    .remote_dom(rem), .bus_level(bus_in));
  ltm_mode_ctrl #(.DOM_TIMEOUT_TICKS(TO)) u_ltm_mode_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .txd_in(txd_pin),
    .mode_select(ms), .wake_in(wk), .bus_in(bus_in), .supply_low(uv),
    .rx_stall(stall), .bus_drive(bus_drive), .rxd_out(rxd_out),
    .txd_out(txd_out), .txd_oe(txd_oe), .txd_strong(txd_strong),
    .regulator_switch_out(reg_sw), .termination_en(term_en),
    .rx_buf_ready(rdy), .mode_out(mode));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // bus level expected from the transmit level in normal mode
  function automatic logic exp_bus(logic t, logic u);
    return t || u;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(string nm, logic [1:0] e, logic [1:0] g);
    @(negedge ref_clk);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    cyc(16);
    sys_rst <= 1'b0;
    chk("mode", LTM_FAILSAFE, mode);
    chk("regulator", 1'b1, reg_sw);
    cyc(1);
    ms <= 1'b1;
    cyc(8);
    chk("mode", LTM_NORMAL, mode);
    chk("termination", 1'b1, term_en);
    chk("bus_drive", 1'b0, bus_drive);
    cyc(1);
    txd_q <= 1'b1;
    cyc(500);
    $display("test power_up done");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      b = seed[0];
      txd_q <= b;
      stall <= seed[1];
      cyc(4);
      stall <= 1'b0;
      cyc(12);
      chk("bus_drive", !exp_bus(b, 1'b0), bus_drive);
      chk("rxd_out", exp_bus(b, 1'b0), rxd_out);
      cyc(1);
    end
    txd_q <= 1'b1;
    stall <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rem <= ~rem;
      cyc(4);
    end
    chk("rx_buf_ready", 1'b0, rdy);
    cyc(1);
    stall <= 1'b0;
    cyc(30);
    chk("rxd_out", 1'b0, rxd_out);
    chk("rx_buf_ready", 1'b1, rdy);
    cyc(1);
    rem <= 1'b0;
    uv <= 1'b1;
    txd_q <= 1'b0;
    cyc(10);
    chk("bus_drive", 1'b0, bus_drive);
    cyc(1);
    uv <= 1'b0;
    cyc(10);
    chk("bus_drive", 1'b1, bus_drive);
    cyc(TO * TICK_CYCLES + 100);
    chk("bus_drive", 1'b0, bus_drive);
    cyc(1);
    txd_q <= 1'b1;
    cyc(200);
    txd_q <= 1'b0;
    cyc(10);
    chk("bus_drive", 1'b0, bus_drive);
    cyc(1);
    txd_q <= 1'b1;
    cyc(500);
    txd_q <= 1'b0;
    cyc(10);
    chk("bus_drive", 1'b1, bus_drive);
    cyc(1);
    txd_q <= 1'b1;
    cyc(20);
    $display("test transmit done");
    ms <= 1'b0;
    cyc(8);
    chk("mode", LTM_SLEEP, mode);
    chk("regulator", 1'b0, reg_sw);
    chk("termination", 1'b0, term_en);
    cyc(1);
    txd_q <= 1'b0;
    cyc(10);
    chk("bus_drive", 1'b0, bus_drive);
    cyc(1);
    txd_q <= 1'b1;
    rem <= 1'b1;
    cyc(60 * TICK_CYCLES);
    rem <= 1'b0;
    cyc(20);
    chk("mode", LTM_SLEEP, mode);
    cyc(1);
    rem <= 1'b1;
    cyc(95 * TICK_CYCLES);
    rem <= 1'b0;
    cyc(20);
    chk("mode", LTM_FAILSAFE, mode);
    chk("regulator", 1'b1, reg_sw);
    chk("txd_oe", 1'b1, txd_oe);
    chk("txd_pin", 1'b1, txd_pin);
    chk("rxd_out", 1'b0, rxd_out);
    cyc(1);
    ms <= 1'b1;
    cyc(8);
    chk("txd_oe", 1'b0, txd_oe);
    chk("rxd_out", 1'b1, rxd_out);
    cyc(1);
    ms <= 1'b0;
    wk <= 1'b0;
    cyc(20 * TICK_CYCLES);
    wk <= 1'b1;
    cyc(400);
    chk("mode", LTM_SLEEP, mode);
    cyc(1);
    wk <= 1'b0;
    cyc(40 * TICK_CYCLES);
    chk("mode", LTM_FAILSAFE, mode);
    chk("txd_pin", 1'b0, txd_pin);
    cyc(1);
    wk <= 1'b1;
    $display("test wake done");
    sys_rst <= 1'b1;
    cyc(16);
    sys_rst <= 1'b0;
    chk("mode", LTM_FAILSAFE, mode);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
